// file: rtl/bcw_bus_cycle.sv
module bcw_bus_cycle (
   // Double-rate clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Pins from the external decode logic
   input wire logic readyN,
   input wire logic pipelined_addr_req_n,
   input wire logic half_width_bus_n,
   input wire logic [31:0] busDataIn,
   // Pins to the bus
   output logic addr_strobe_n,
   output bcw_pkg::bcw_bus_t busOut,
   // Core requests
   input wire logic codeFetchReq,
   input wire logic dataReqValid,
   input wire bcw_pkg::bcw_req_t dataReq,
   output logic reqReady,
   // Control flow from the core
   input wire logic farJumpValid,
   input wire logic [15:0] farJumpSel,
   input wire logic [15:0] farJumpIp,
   input wire logic [31:0] farJumpBase,
   input wire logic protEnable,
   // Results and status
   output logic cycleDone,
   output logic [31:0] readData,
   output logic doneHalfWidth,
   output logic realMode,
   output logic [15:0] csSel,
   output logic [15:0] instruction_pointer,
   output logic [bcw_pkg::BCW_WAIT_W-1:0] waitCount
);
   import bcw_pkg::*;

   // ==========================================================
   // Declarations
   logic phaseEn; // One pulse per bus state
   bcw_state_t state_q, state_d; // Bus state
   logic addrStrobeN_q; // Strobe pin
   bcw_bus_t bus_q, bus_d; // Address phase pins
   logic reqReady_q; // Idle, request may be taken
   logic done_q; // End of cycle pulse
   logic [31:0] readData_q; // Captured read data
   logic halfWidth_q; // Narrow bus seen at end
   logic realMode_q; // Real mode flag
   logic [15:0] csSel_q; // Code segment selector
   logic [15:0] ip_q; // Instruction pointer
   logic [31:0] csBase_q; // Code segment base
   logic [BCW_WAIT_W-1:0] waitCnt_q; // Waits of current cycle
   logic firstFetch_q; // No fetch done since reset
   logic startCycle; // Leave idle this state
   logic endCycle; // Termination sampled at end of T2
   logic addWait; // Termination absent at end of T2
   logic [31:0] fetchAddr; // Code fetch physical address
   logic [31:0] realBase; // Selector shifted into a base

   // ==========================================================
   // State clock divider
   bcw_phase_div uDiv (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .phaseEn(phaseEn)
   );

   // ==========================================================
   // Decode
   assign startCycle = phaseEn && (state_q == BCW_IDLE) && (codeFetchReq || dataReqValid);
   assign endCycle = phaseEn && (state_q == BCW_T2) && !readyN;
   assign addWait = phaseEn && (state_q == BCW_T2) && readyN;
   assign fetchAddr = csBase_q + {16'h0000, ip_q};
   assign realBase = {16'h0000, farJumpSel} << BCW_SEG_SHIFT;

   // Next bus state; address is never sent before the cycle ends,
   // so the pipelining request is not acted on
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         BCW_IDLE: begin
            if (startCycle) begin
               state_d = BCW_T1;
            end
         end
         BCW_T1: begin
            if (phaseEn) begin
               state_d = BCW_T2;
            end
         end
         BCW_T2: begin
            if (endCycle) begin
               state_d = BCW_IDLE;
            end
         end
         default: begin
            state_d = BCW_IDLE;
         end
      endcase
   end

   // Address phase, code fetch before data
   always_comb begin
      bus_d = bus_q;
      if (startCycle && codeFetchReq) begin
         bus_d.addr = fetchAddr[31:2];
         bus_d.byteLaneEnablesN = 4'h0;
         bus_d.write = 1'b0;
         bus_d.code = 1'b1;
      end else if (startCycle) begin
         bus_d.addr = dataReq.addr[31:2];
         bus_d.byteLaneEnablesN = ~dataReq.byteEn;
         bus_d.write = dataReq.write;
         bus_d.code = 1'b0;
      end
   end

   // ==========================================================
   // Bus cycle registers
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_q <= BCW_IDLE;
         addrStrobeN_q <= 1'b1;
         bus_q <= '0;
         reqReady_q <= 1'b0;
         done_q <= 1'b0;
         readData_q <= 32'h0;
         halfWidth_q <= 1'b0;
         waitCnt_q <= '0;
      end else begin
         state_q <= state_d;
         addrStrobeN_q <= (state_d != BCW_T1);
         bus_q <= bus_d;
         reqReady_q <= (state_d == BCW_IDLE);
         done_q <= endCycle;
         if (endCycle) begin
            readData_q <= busDataIn;
            halfWidth_q <= !half_width_bus_n;
         end
         if (startCycle) begin
            waitCnt_q <= '0;
         end else if (addWait) begin
            waitCnt_q <= waitCnt_q + 16'h0001;
         end
      end
   end

   // ==========================================================
   // Code pointer and mode
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         csSel_q <= BCW_RESET_CS_SEL;
         ip_q <= BCW_RESET_IP;
         csBase_q <= BCW_RESET_CS_BASE;
         realMode_q <= 1'b1;
         firstFetch_q <= 1'b1;
      end else begin
         if (protEnable) begin
            realMode_q <= 1'b0;
         end
         if (farJumpValid) begin
            // Far jump reloads the base and wins over the step
            csSel_q <= farJumpSel;
            ip_q <= farJumpIp;
            csBase_q <= realMode_q ? realBase : farJumpBase;
         end else if (endCycle && bus_q.code) begin
            ip_q <= ip_q + BCW_FETCH_STEP;
         end
         if (endCycle && bus_q.code) begin
            firstFetch_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Outputs
   assign addr_strobe_n = addrStrobeN_q;
   assign busOut = bus_q;
   assign reqReady = reqReady_q;
   assign cycleDone = done_q;
   assign readData = readData_q;
   assign doneHalfWidth = halfWidth_q;
   assign realMode = realMode_q;
   assign csSel = csSel_q;
   assign instruction_pointer = ip_q;
   assign waitCount = waitCnt_q;

   // ==========================================================
   // Checks
   strobe_in_t1_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !addr_strobe_n |-> (state_q == BCW_T1))
      else $error("strobe asserted outside first state");

   strobe_two_clk_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $fell(addr_strobe_n) |=> !addr_strobe_n ##1 addr_strobe_n)
      else $error("strobe did not span two clocks");

   zero_wait_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ($fell(addr_strobe_n) ##3 !readyN) |=> cycleDone && waitCount == 16'h0000)
      else $error("zero wait cycle not two states");

   wait_count_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (state_q == BCW_T2 && phaseEn && readyN) |=> waitCount == $past(waitCount) + 16'h0001)
      else $error("wait state not counted");

   no_self_end_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      cycleDone |-> $past(!readyN) && $past(state_q) == BCW_T2)
      else $error("cycle ended without termination");

   no_pipeline_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $fell(addr_strobe_n) |-> $past(state_q) == BCW_IDLE)
      else $error("address issued during a cycle");

   reset_ptr_a: assert property (
      @(posedge core_clk)
      !rst_b |=> csSel == 16'hf000 && instruction_pointer == 16'hfff0 && realMode)
      else $error("wrong code pointer after reset");

   mode_exit_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      $fell(realMode) |-> $past(protEnable))
      else $error("left real mode unasked");

   base_hold_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      !$stable(csBase_q) |-> $past(farJumpValid))
      else $error("code base changed without far jump");

   real_base_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      (farJumpValid && realMode) |=> csBase_q == {12'h000, $past(farJumpSel), 4'h0})
      else $error("real mode base not selector times sixteen");

   first_fetch_a: assert property (
      @(posedge core_clk) disable iff (!rst_b)
      ($fell(addr_strobe_n) && busOut.code && firstFetch_q) |-> busOut.addr == 30'h3ffffffc)
      else $error("first fetch not at top of memory");

endmodule

// file: rtl/bcw_phase_div.sv
module bcw_phase_div (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Bus state enable
   output logic phaseEn
);
   import bcw_pkg::*;

   // ==========================================================
   // Divider
   logic [1:0] cnt_q; // Double-rate clocks into the state
   logic lastClk; // Final clock of a bus state

   assign lastClk = (cnt_q == 2'(BCW_CLKS_PER_STATE - 1));

   // Count double-rate clocks, one enable per bus state
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         cnt_q <= 2'h0;
      end else if (lastClk) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
      end
   end

   assign phaseEn = lastClk;

endmodule

// file: rtl/bcw_pkg.sv
package bcw_pkg;

   // ==========================================================
   // Reset values of the code pointer
   localparam logic [15:0] BCW_RESET_CS_SEL = 16'hf000;
   localparam logic [15:0] BCW_RESET_IP = 16'hfff0;
   localparam logic [31:0] BCW_RESET_CS_BASE = 32'hffff0000;

   // ==========================================================
   // Real mode address forming
   localparam int unsigned BCW_SEG_SHIFT = 4;
   localparam logic [15:0] BCW_FETCH_STEP = 16'h0004;

   // ==========================================================
   // Bus state timing
   localparam int unsigned BCW_CLKS_PER_STATE = 2;
   localparam int unsigned BCW_WAIT_W = 16;

   // ==========================================================
   // Bus states
   typedef enum logic [1:0] {
      BCW_IDLE = 2'b00,
      BCW_T1 = 2'b01,
      BCW_T2 = 2'b10
   } bcw_state_t;

   // Data request from the core
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [3:0] byteEn;
   } bcw_req_t;

   // Address phase driven to the pins
   typedef struct packed {
      logic [31:2] addr;
      logic [3:0] byteLaneEnablesN;
      logic write;
      logic code;
   } bcw_bus_t;

endpackage

// file: sim/bcw_decode_model.sv
// ==========
// Address decode and termination model for the far side of the bus
module bcw_decode_model (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // Bus from the device
   input wire logic addr_strobe_n,
   input wire bcw_pkg::bcw_bus_t busOut,
   // Bench control: withhold termination
   input wire logic stall,
   // Replies to the device
   output logic readyN,
   output logic half_width_bus_n,
   output logic [31:0] busDataIn,
   // Per-lane RAM write strobes
   output logic [3:0] ramWeN
);
   timeunit 1ns;
   timeprecision 1ps;
   import bcw_pkg::*;
   logic busy_q; // Cycle in progress
   logic [7:0] cnt_q; // Clocks since strobe seen
   logic [1:0] waits_q; // Decoded wait count
   logic hit; // Termination this clock
   logic [31:0] pat; // Read pattern
   // Terminate at the end of the second state plus the decoded waits, on a state boundary
   assign hit = busy_q && !stall && cnt_q >= {5'h00, waits_q, 1'b0} + 8'h02 && !cnt_q[0];
   assign readyN = !hit;
   // Narrow region asserts the half-width input for the whole cycle
   assign half_width_bus_n = !((busy_q || !addr_strobe_n) && busOut.addr[31:28] == 4'h1);
   assign pat = {busOut.addr, 2'b00} ^ 32'h5a5a5a5a;
   // Data off the bus is garbage outside the termination clock
   assign busDataIn = hit ? pat : ~pat;
   assign ramWeN = (busy_q && busOut.write) ? busOut.byteLaneEnablesN : 4'hf;
   // Cycle tracker
   always_ff @(posedge core_clk) begin
      if (!rst_b || hit) begin
         busy_q <= 1'b0;
         cnt_q <= 8'h00;
      end else if (busy_q) begin
         cnt_q <= cnt_q + 8'h01;
      end else if (!addr_strobe_n) begin
         busy_q <= 1'b1;
         waits_q <= busOut.addr[5:4];
      end
   end
endmodule

// file: sim/tb.sv
// ==========
// Bench for the bus cycle block
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import bcw_pkg::*;
   typedef struct packed {bcw_req_t req; logic [1:0] w; logic narrow;} bcw_row_t;
   logic core_clk, rst_b, readyN, pipelined_addr_req_n, half_width_bus_n, addr_strobe_n, stall;
   logic codeFetchReq, dataReqValid, reqReady, farJumpValid, protEnable, cycleDone, doneHalfWidth, realMode;
   logic [15:0] farJumpSel, farJumpIp, csSel, instruction_pointer, waitCount;
   logic [31:0] farJumpBase, busDataIn, readData;
   logic [3:0] ramWeN, weSeen;
   bcw_req_t dataReq;
   bcw_bus_t busOut;
   int n_mismatch, tests_run, k, ls;
   // Ordinary cases: request, waits, narrow flag
   bcw_row_t rows [4] = '{'{'{32'h00000100, 1'b0, 4'hf}, 2'd0, 1'b0}, '{'{32'h10000010, 1'b1, 4'h1}, 2'd1, 1'b1},
      '{'{32'h00000024, 1'b1, 4'h6}, 2'd2, 1'b0}, '{'{32'h20000038, 1'b0, 4'h8}, 2'd3, 1'b0}};
   bcw_bus_cycle u_dut (.core_clk(core_clk), .rst_b(rst_b), .readyN(readyN),
      .pipelined_addr_req_n(pipelined_addr_req_n), .half_width_bus_n(half_width_bus_n), .busDataIn(busDataIn),
      .addr_strobe_n(addr_strobe_n), .busOut(busOut), .codeFetchReq(codeFetchReq), .dataReqValid(dataReqValid),
      .dataReq(dataReq), .reqReady(reqReady), .farJumpValid(farJumpValid), .farJumpSel(farJumpSel),
      .farJumpIp(farJumpIp), .farJumpBase(farJumpBase), .protEnable(protEnable), .cycleDone(cycleDone),
      .readData(readData), .doneHalfWidth(doneHalfWidth), .realMode(realMode), .csSel(csSel),
      .instruction_pointer(instruction_pointer), .waitCount(waitCount));
   bcw_decode_model u_far (.core_clk(core_clk), .rst_b(rst_b), .addr_strobe_n(addr_strobe_n), .busOut(busOut),
      .stall(stall), .readyN(readyN), .half_width_bus_n(half_width_bus_n), .busDataIn(busDataIn), .ramWeN(ramWeN));
   // ==========
   // Clock and watchdog
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   initial begin
      repeat (3000) @(posedge core_clk);
      n_mismatch++;
      final_report();
   end
   // ==========
   // Helpers
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One bus cycle; k counts clocks from strobe fall to done
   task automatic run(input logic code, input bcw_req_t r, input int lim);
      @(posedge core_clk);
      codeFetchReq <= code;
      dataReqValid <= !code;
      dataReq <= r;
      repeat (20) if (addr_strobe_n !== 1'b0) @(negedge core_clk);
      k = 0;
      ls = 1;
      weSeen = 4'hf;
      @(posedge core_clk);
      codeFetchReq <= 1'b0;
      dataReqValid <= 1'b0;
      do begin
         @(negedge core_clk);
         k++;
         ls += int'(addr_strobe_n === 1'b0);
         weSeen &= ramWeN;
      end while (cycleDone !== 1'b1 && k < lim);
   endtask
   task automatic fetch(input logic [31:0] a);
      run(1'b1, rows[0].req, 100);
      chk("fetchAddr", a, {busOut.addr, 2'b00});
      chk("fetchCode", 1, busOut.code);
      chk("fetchClocks", 4 + 2 * a[5:4], k);
      chk("strobeClocks", 2, ls);
      chk("fetchData", a ^ 32'h5a5a5a5a, readData);
      chk("reqReady", 1, reqReady);
   endtask
   task automatic rst_check();
      @(negedge core_clk);
      chk("csSel", 32'h0000f000, csSel);
      chk("ip", 32'h0000fff0, instruction_pointer);
      chk("realMode", 1, realMode);
      chk("reqReadyRst", 0, reqReady);
   endtask
   task automatic jump(input logic [15:0] s, input logic [15:0] p, input logic [31:0] b);
      @(posedge core_clk);
      farJumpValid <= 1'b1;
      farJumpSel <= s;
      farJumpIp <= p;
      farJumpBase <= b;
      @(posedge core_clk);
      farJumpValid <= 1'b0;
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // ==========
   // Main sequence
   initial begin
      {codeFetchReq, dataReqValid, farJumpValid, protEnable, stall} <= 5'h00;
      pipelined_addr_req_n <= 1'b1;
      rst_b <= 1'b0;
      dataReq <= '0;
      {farJumpSel, farJumpIp, farJumpBase} <= 64'h0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rst_check();
      fetch(32'hfffffff0);
      // Table of data cycles
      foreach (rows[i]) begin
         run(1'b0, rows[i].req, 100);
         chk("addr", {rows[i].req.addr[31:2], 2'b00}, {busOut.addr, 2'b00});
         chk("lanes", 4'(~rows[i].req.byteEn), busOut.byteLaneEnablesN);
         chk("ramWe", rows[i].req.write ? 4'(~rows[i].req.byteEn) : 4'hf, weSeen);
         chk("clocks", 4 + 2 * rows[i].w, k);
         chk("waits", rows[i].w, waitCount);
         chk("narrow", rows[i].narrow, doneHalfWidth);
         if (!rows[i].req.write) chk("data", {rows[i].req.addr[31:2], 2'b00} ^ 32'h5a5a5a5a, readData);
      end
      jump(16'h1234, 16'h0010, 32'hdead0000);
      fetch(32'h00012350);
      @(posedge core_clk) protEnable <= 1'b1;
      @(posedge core_clk) protEnable <= 1'b0;
      @(negedge core_clk) chk("protMode", 0, realMode);
      jump(16'h0008, 16'h0020, 32'h00400000);
      fetch(32'h00400020);
      // Termination withheld: cycle must not end
      @(posedge core_clk) stall <= 1'b1;
      run(1'b1, rows[0].req, 60);
      chk("hangDone", 0, cycleDone);
      chk("hangWaits", 29, waitCount);
      @(posedge core_clk) stall <= 1'b0;
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (cycleDone !== 1'b1 && k < 10);
      chk("doneAfterRelease", 1, cycleDone);
      // Reset in mid-run restores the code pointer
      @(posedge core_clk) rst_b <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      rst_check();
      fetch(32'hfffffff0);
      final_report();
   end
endmodule
